/* File: core/hdlc_link_irq_enable.v */
// Purpose: Interrupt enable gating for the second data link controllers
// Assumes: Event pulses come from logic on clk_sys, one cycle each
// Notes: Status register clears on read; enable register is read/write
//
// Function
// RL1 - Transmit-begin event raises interrupt when enable bit 6 set
// RL2 - Receive-begin event raises interrupt when enable bit 5 set
// RL3 - Transmit-done event raises interrupt when enable bit 4 set
// RL4 - Receive-done event raises interrupt when enable bit 3 set
// RL5 - Check-sequence mismatch raises interrupt when enable bit 2 set
// RL6 - Seven-ones abort raises interrupt when enable bit 1 set
// RL7 - Idle flag octet 0x7E raises interrupt when enable bit 0 set
// RL8 - Status flags latch on event, clear when status register is read
// RL9 - Receive-done also declared when receive buffer becomes full
// RL10 - Request high while any enabled flag set; enables reset to zero
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "hdlc_irq_consts.vh"
module hdlc_link_irq_enable (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Register port
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   // Event pulses from the controllers
   input wire tx_msg_begin,
   input wire rx_msg_begin,
   input wire tx_msg_done,
   input wire rx_msg_done,
   input wire rx_buf_full,
   input wire check_mismatch,
   input wire abort_seen,
   input wire flag_idle,
   // Enable bits and interrupt
   output wire [6:0] irq_enable,
   output wire irq
);
   // ------------------------------------------------
   // Event collection
   // ------------------------------------------------
   wire [`NUM_EVENTS-1:0] event_vec;
   wire [`NUM_EVENTS-1:0] flag_vec;
   wire status_rd;
   reg [6:0] enable_ff;
   reg [7:0] rdata_ff;
   reg irq_ff;
   reg [7:0] nxt_rdata;
   wire nxt_irq;
   assign event_vec[`BIT_TX_BEGIN] = tx_msg_begin; // RL1
   assign event_vec[`BIT_RX_BEGIN] = rx_msg_begin; // RL2
   assign event_vec[`BIT_TX_DONE] = tx_msg_done; // RL3
   assign event_vec[`BIT_RX_DONE] = rx_msg_done | rx_buf_full; // RL4 RL9
   assign event_vec[`BIT_CHECK] = check_mismatch; // RL5
   assign event_vec[`BIT_ABORT] = abort_seen; // RL6
   assign event_vec[`BIT_IDLE] = flag_idle; // RL7
   assign status_rd = reg_rd & (reg_addr == `REG_STATUS);
   // ------------------------------------------------
   // Sticky flags
   // ------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_EVENTS; gi = gi + 1) begin : g_flag
         event_flag u_flag (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .set_pulse(event_vec[gi]),
            .clr_pulse(status_rd), // RL8
            .flag(flag_vec[gi])
         );
      end
   endgenerate
   // ------------------------------------------------
   // Enable register
   // ------------------------------------------------
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enable_ff <= `ENABLE_RESET; // RL10
      end else if (reg_wr && (reg_addr == `REG_ENABLE)) begin
         enable_ff <= reg_wdata[6:0];
      end
   end
   // ------------------------------------------------
   // Read data
   // ------------------------------------------------
   always @* begin
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `REG_STATUS: nxt_rdata = {1'b0, flag_vec};
            `REG_ENABLE: nxt_rdata = {1'b0, enable_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end
   // ------------------------------------------------
   // Interrupt request
   // ------------------------------------------------
   assign nxt_irq = |(flag_vec & enable_ff & ~{7{status_rd}}); // RL10
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= `STATUS_RESET;
         irq_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq | (|(event_vec & enable_ff)); // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL9
      end
   end
   assign reg_rdata = rdata_ff;
   assign irq_enable = enable_ff;
   assign irq = irq_ff;
endmodule // hdlc_link_irq_enable

/* File: core/hdlc_irq_consts.vh */
// Purpose: Constants for the second data link interrupt enable block
// Assumes: Included by bare name
// Notes: Offsets are register indices on the plain register port
`ifndef HDLC_IRQ_CONSTS_VH
`define HDLC_IRQ_CONSTS_VH
`define ADDR_W 4
`define REG_STATUS 4'h6
`define REG_ENABLE 4'h7
`define ENABLE_RESET 7'h00
`define STATUS_RESET 8'h00
`define ENABLE_MASK 8'h7f
`define BIT_TX_BEGIN 6
`define BIT_RX_BEGIN 5
`define BIT_TX_DONE 4
`define BIT_RX_DONE 3
`define BIT_CHECK 2
`define BIT_ABORT 1
`define BIT_IDLE 0
`define NUM_EVENTS 7
`endif

/* File: core/event_flag.v */
// Purpose: One sticky reset-upon-read event flag
// Assumes: Event and read pulses are on clk_sys
// Notes: Set wins over clear
`timescale 1ns/100ps
module event_flag (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Control
   input wire set_pulse,
   input wire clr_pulse,
   // State
   output wire flag
);
   reg flag_ff;
   wire nxt_flag;
   assign nxt_flag = set_pulse | (flag_ff & ~clr_pulse);
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end
   assign flag = flag_ff;
endmodule // event_flag

/* File: sim/irq_en_monitor.sv */
// Purpose: Port assertions for the interrupt enable block
// Assumes: One clock domain, fixed latencies
// Notes: Bound from the tb file
`timescale 1ns/100ps
`include "hdlc_irq_consts.vh"
module irq_en_monitor (
   input wire clk_sys, rstn, reg_wr, reg_rd, irq,
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_rdata,
   input wire tx_msg_begin, rx_msg_begin, tx_msg_done, rx_msg_done,
   input wire rx_buf_full, check_mismatch, abort_seen, flag_idle,
   input wire [6:0] irq_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire hold = !reg_wr;
   chk_tx_begin_irq: assert property
      (tx_msg_begin && irq_enable[6] && hold |=> irq) else $error("tx b");
   chk_rx_begin_irq: assert property
      (rx_msg_begin && irq_enable[5] && hold |=> irq) else $error("rx b");
   chk_tx_done_irq: assert property
      (tx_msg_done && irq_enable[4] && hold |=> irq) else $error("tx d");
   chk_rx_done_irq: assert property
      (rx_msg_done && irq_enable[3] && hold |=> irq) else $error("rx d");
   chk_check_irq: assert property
      (check_mismatch && irq_enable[2] && hold |=> irq) else $error("chk");
   chk_abort_irq: assert property
      (abort_seen && irq_enable[1] && hold |=> irq) else $error("abort");
   chk_idle_irq: assert property
      (flag_idle && irq_enable[0] && hold |=> irq) else $error("idle");
   chk_buf_full_irq: assert property
      (rx_buf_full && irq_enable[3] && hold |=> irq) else $error("full");
   chk_flag_read: assert property (flag_idle && !reg_rd ##1 !reg_rd
      ##1 reg_rd && reg_addr == `REG_STATUS |=> reg_rdata[0])
      else $error("flag lost");
   chk_irq_needs_en: assert property
      (irq && !$past(reg_wr) |-> irq_enable != 7'h00) else $error("irq");
endmodule // irq_en_monitor

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: Fixed latencies, no handshake waits
// Notes: ev[7] drives the buffer-full event
`timescale 1ns/100ps
`include "hdlc_irq_consts.vh"
module tb;
   reg clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00, ev = 8'h00, d;
   wire [7:0] reg_rdata;
   wire [6:0] irq_enable;
   wire irq;
   integer err_count = 0, checked = 0, i, b;
   always #2.5 clk_sys = ~clk_sys;
   hdlc_link_irq_enable u_dut (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_msg_begin(ev[6]),
      .rx_msg_begin(ev[5]), .tx_msg_done(ev[4]), .rx_msg_done(ev[3]),
      .rx_buf_full(ev[7]), .check_mismatch(ev[2]), .abort_seen(ev[1]),
      .flag_idle(ev[0]), .irq_enable(irq_enable), .irq(irq));
   task chk(input [7:0] got, input [7:0] exp); begin
      checked = checked + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   end endtask
   task wr(input [3:0] a, input [7:0] v); begin
      @(posedge clk_sys); reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
      @(posedge clk_sys); reg_wr <= 0;
   end endtask
   task rd(input [3:0] a, output [7:0] v); begin
      @(posedge clk_sys); reg_addr <= a; reg_rd <= 1;
      @(posedge clk_sys); reg_rd <= 0; #1 v = reg_rdata;
   end endtask
   task pulse(input integer n); begin
      @(posedge clk_sys); ev[n] <= 1;
      @(posedge clk_sys); ev <= 8'h00; #1;
   end endtask
   task t_regs; begin
      rd(`REG_ENABLE, d); chk(d, `ENABLE_RESET);
      rd(`REG_STATUS, d); chk(d, `STATUS_RESET);
      wr(`REG_ENABLE, 8'hff); wr(4'h3, 8'h00);
      rd(`REG_ENABLE, d); chk(d, `ENABLE_MASK);
      rd(4'h3, d); chk(d, 8'h00);
      $display("t_regs done");
   end endtask
   task t_events; begin
      for (i = 0; i < 8; i = i + 1) begin
         b = (i == 7) ? 3 : i;
         wr(`REG_ENABLE, 8'h01 << b); pulse(i);
         chk(irq, 1);
         rd(`REG_STATUS, d); chk(d, 8'h01 << b);
         chk(irq, 0);
         wr(`REG_ENABLE, 8'h7f ^ (8'h01 << b)); pulse(i);
         chk(irq, 0);
         rd(`REG_STATUS, d); chk(d, 8'h01 << b);
      end
      $display("t_events done");
   end endtask
   task t_clear; begin
      wr(`REG_ENABLE, 8'h01); wr(`REG_STATUS, 8'h7f);
      rd(`REG_STATUS, d); chk(d, 8'h00);
      @(posedge clk_sys); reg_addr <= `REG_STATUS; reg_rd <= 1; ev[0] <= 1;
      @(posedge clk_sys); reg_rd <= 0; ev <= 8'h00; #1;
      chk(reg_rdata, 8'h00);
      chk(irq, 1);
      @(posedge clk_sys); #1;
      chk(reg_rdata, 8'h00);
      chk(irq, 1);
      rd(`REG_STATUS, d); chk(d, 8'h01);
      chk(irq, 0);
      $display("t_clear done");
   end endtask
   task final_report; begin
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   end endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1;
      t_regs; t_events; t_clear; final_report;
   end
endmodule // tb
bind hdlc_link_irq_enable irq_en_monitor u_mon (.*);
